// file: inc/retention_map.svh
// Purpose: offsets, field positions, reset values for the retention block
// Assumes: APB, 32-bit data, word aligned registers
// Notes: constants only
`ifndef RETENTION_MAP_SVH
`define RETENTION_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_TIMER 12'h008
`define OFF_WDCS 12'h00C
`define OFF_RSTCTL 12'h010
`define OFF_PORTAB 12'h014
`define OFF_PORTC 12'h018

// ----------------------------------------------------------------
// control bits and fields
// ----------------------------------------------------------------
`define CTRL_MANUAL 0
`define CTRL_STANDBY 1
`define CTRL_SLEEP 2
`define WDCS_OVF 7
`define WDCS_MODE 6
`define WDCS_EN 5
`define WDCS_CKS_HI 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_TIMER 32'h0000_0000
`define RST_WDCS 8'h18
`define RST_RSTCTL 8'h1F
`define RST_PORTAB 32'h0000_0000

`endif

// file: inc/retention_pkg.sv
// Purpose: types for the retention block
// Assumes: nothing
// Notes: strobe bundle and power state
package retention_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PS_RUN,
    PS_STANDBY,
    PS_SLEEP
  } power_state_t;

  typedef struct packed {
    logic timer_clr;
    logic wdcs_clr;
    logic rstctl_clr;
    logic portab_clr;
  } init_strobes_t;

endpackage : retention_pkg

// file: rtl/reset_standby_retention.sv
// Purpose: per-state initialization of peripheral registers
// Assumes: APB slave, single clock pclk, pins synchronous
// Notes: zero wait state APB, pslverr on unmapped address
//
// Behaviour
// (RULE1) timer registers cleared on power-on, manual reset, standby entry; held in sleep
// (RULE2) standby entry clears watchdog status bits 7-5, keeps clock select 2-0
// (RULE3) reset control register kept on watchdog reset, else initialized
// (RULE4) port C read gives live pins in low byte, high byte undefined
// (RULE5) port A/B data cleared only on power-on reset
// (RULE6) separate init strobe per retention class from reset source and state
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "retention_map.svh"
module reset_standby_retention
  import retention_pkg::*;
#(
  parameter int TIMER_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic manual_reset,
  input wire logic wdt_reset,
  input wire logic standby_req,
  input wire logic sleep_req,
  input wire logic [7:0] port_c_pins,
  output logic [3:0] init_strobes,
  output logic [1:0] power_state
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [7:0] WDCS_INIT = `RST_WDCS;
  power_state_t ps_q;
  power_state_t ps_d;
  logic standby_entry;
  logic manual_any;
  logic wr;
  logic setup;
  logic hit_ctrl;
  logic hit_status;
  logic hit_timer;
  logic hit_wdcs;
  logic hit_rstctl;
  logic hit_portab;
  logic hit_portc;
  logic hit_any;
  logic wr_ctrl;
  logic wr_timer;
  logic wr_wdcs;
  logic wr_rstctl;
  logic wr_portab;
  logic overflow_flag_q;
  logic timer_mode_select_q;
  logic timer_enable_bit_q;
  logic [1:0] wdcs_spare_q;
  logic [2:0] clock_select_field_q;
  logic [7:0] wdcs_rd;
  logic [7:0] rstctl_q;
  logic [TIMER_W-1:0] timer_q;
  logic [31:0] portab_q;
  logic [2:0] sw_ctrl_q;
  logic [31:0] rdata_d;
  logic rerr_d;
  init_strobes_t str;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign hit_ctrl = paddr == `OFF_CTRL;
  assign hit_status = paddr == `OFF_STATUS;
  assign hit_timer = paddr == `OFF_TIMER;
  assign hit_wdcs = paddr == `OFF_WDCS;
  assign hit_rstctl = paddr == `OFF_RSTCTL;
  assign hit_portab = paddr == `OFF_PORTAB;
  assign hit_portc = paddr == `OFF_PORTC;
  assign hit_any = hit_ctrl || hit_status || hit_timer || hit_wdcs || hit_rstctl ||
    hit_portab || hit_portc;
  assign wr_ctrl = wr && hit_ctrl;
  assign wr_timer = wr && hit_timer;
  assign wr_wdcs = wr && hit_wdcs;
  assign wr_rstctl = wr && hit_rstctl;
  assign wr_portab = wr && hit_portab;

  // ----------------------------------------------------------------
  // power state and reset source
  // ----------------------------------------------------------------
  assign manual_any = manual_reset || (wr_ctrl && pwdata[`CTRL_MANUAL]);
  assign standby_entry = (ps_q != PS_STANDBY) &&
    (standby_req || (wr_ctrl && pwdata[`CTRL_STANDBY]));

  always_comb begin
    ps_d = ps_q;
    if (manual_any) begin
      ps_d = PS_RUN;
    end else if (standby_entry) begin
      ps_d = PS_STANDBY;
    end else if (sleep_req || sw_ctrl_q[`CTRL_SLEEP]) begin
      ps_d = PS_SLEEP;
    end else if (!standby_req && !sw_ctrl_q[`CTRL_STANDBY]) begin
      ps_d = PS_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= PS_RUN;
    end else begin
      ps_q <= ps_d;
    end
  end

  // ----------------------------------------------------------------
  // software control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_ctrl_q <= 3'h0;
    end else if (wr_ctrl) begin
      sw_ctrl_q <= {pwdata[`CTRL_SLEEP], pwdata[`CTRL_STANDBY], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // init strobes per retention class
  // ----------------------------------------------------------------
  always_comb begin
    str.timer_clr = manual_any || standby_entry; // RULE1 RULE6
    str.wdcs_clr = manual_any || standby_entry; // RULE2 RULE6
    str.rstctl_clr = manual_any ? !wdt_reset : standby_entry; // RULE3 RULE6
    str.portab_clr = 1'b0; // RULE5 RULE6
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_strobes <= 4'h0;
    end else begin
      init_strobes <= str;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state <= 2'h0;
    end else begin
      power_state <= ps_q;
    end
  end

  // ----------------------------------------------------------------
  // timer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= TIMER_W'(`RST_TIMER);
    end else if (str.timer_clr) begin
      timer_q <= TIMER_W'(`RST_TIMER); // RULE1
    end else if (wr_timer) begin
      timer_q <= pwdata[TIMER_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // watchdog control/status fields
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= WDCS_INIT[`WDCS_OVF];
    end else if (manual_any) begin
      overflow_flag_q <= WDCS_INIT[`WDCS_OVF];
    end else if (standby_entry) begin
      overflow_flag_q <= 1'b0; // RULE2
    end else if (wr_wdcs) begin
      overflow_flag_q <= pwdata[`WDCS_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_select_q <= WDCS_INIT[`WDCS_MODE];
    end else if (manual_any) begin
      timer_mode_select_q <= WDCS_INIT[`WDCS_MODE];
    end else if (standby_entry) begin
      timer_mode_select_q <= 1'b0; // RULE2
    end else if (wr_wdcs) begin
      timer_mode_select_q <= pwdata[`WDCS_MODE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_enable_bit_q <= WDCS_INIT[`WDCS_EN];
    end else if (manual_any) begin
      timer_enable_bit_q <= WDCS_INIT[`WDCS_EN];
    end else if (standby_entry) begin
      timer_enable_bit_q <= 1'b0; // RULE2
    end else if (wr_wdcs) begin
      timer_enable_bit_q <= pwdata[`WDCS_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdcs_spare_q <= WDCS_INIT[`WDCS_EN-1:`WDCS_CKS_HI+1];
    end else if (manual_any) begin
      wdcs_spare_q <= WDCS_INIT[`WDCS_EN-1:`WDCS_CKS_HI+1];
    end else if (wr_wdcs) begin
      wdcs_spare_q <= pwdata[`WDCS_EN-1:`WDCS_CKS_HI+1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_select_field_q <= WDCS_INIT[`WDCS_CKS_HI:0];
    end else if (manual_any) begin
      clock_select_field_q <= WDCS_INIT[`WDCS_CKS_HI:0];
    end else if (wr_wdcs) begin
      clock_select_field_q <= pwdata[`WDCS_CKS_HI:0]; // RULE2
    end
  end

  assign wdcs_rd = {overflow_flag_q, timer_mode_select_q, timer_enable_bit_q, wdcs_spare_q,
    clock_select_field_q};

  // ----------------------------------------------------------------
  // reset control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rstctl_q <= `RST_RSTCTL;
    end else if (str.rstctl_clr) begin
      rstctl_q <= `RST_RSTCTL; // RULE3
    end else if (wr_rstctl) begin
      rstctl_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // port a/b data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portab_q <= `RST_PORTAB; // RULE5
    end else if (wr_portab) begin
      portab_q <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // apb read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    rerr_d = !hit_any;
    if (hit_ctrl) begin
      rdata_d = {29'h0, sw_ctrl_q};
    end else if (hit_status) begin
      rdata_d = {30'h0, ps_q};
    end else if (hit_timer) begin
      rdata_d = 32'(timer_q);
    end else if (hit_wdcs) begin
      rdata_d = {24'h0, wdcs_rd};
    end else if (hit_rstctl) begin
      rdata_d = {24'h0, rstctl_q};
    end else if (hit_portab) begin
      rdata_d = portab_q;
    end else if (hit_portc) begin
      rdata_d = {24'h0, port_c_pins}; // RULE4
    end
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && rerr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rdata_d;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

endmodule : reset_standby_retention

// file: test/reset_standby_retention_tb_top.sv
// Purpose: bench
// Assumes: APB master here
// Notes: seed 62
`timescale 1ns/1ns
`include "retention_map.svh"
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, x, g); end end
module reset_standby_retention_tb_top
  import retention_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic manual_reset = 0, wdt_reset = 0, standby_req = 0, sleep_req = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic [7:0] port_c_pins = 0;
  logic [3:0] init_strobes;
  logic [1:0] power_state;
  int fails = 0, checked = 0;
  always #4 pclk = ~pclk;
  reset_standby_retention i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .manual_reset, .wdt_reset, .standby_req,
    .sleep_req, .port_c_pins, .init_strobes, .power_state);
  // ----------
  // tasks
  // ----------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, x, v)
  endtask : rd
  function automatic logic [31:0] wd_exp(int k, logic [31:0] w);
    if (k == 2) return w & 32'h1F;
    return k == 3 ? w : {24'h0, `RST_WDCS};
  endfunction : wd_exp
  initial begin
    int k;
    logic [31:0] t, w, r, p;
    logic [7:0] pc;
    void'($urandom(62));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (k = 0; k < 5; k++) begin
      t = $urandom & 32'hFFFF;
      w = $urandom & 32'hC7 | 32'h38;
      r = $urandom & 32'hC0 | 32'h20;
      p = $urandom;
      pc = $urandom;
      port_c_pins <= pc;
      apb(1'b1, `OFF_TIMER, t);
      apb(1'b1, `OFF_WDCS, w);
      apb(1'b1, `OFF_RSTCTL, r);
      apb(1'b1, `OFF_PORTAB, p);
      wdt_reset <= k == 0;
      manual_reset <= k < 2;
      standby_req <= k == 2;
      sleep_req <= k == 3;
      presetn <= k != 4;
      repeat (3) @(posedge pclk);
      `CHK("state", k == 2 ? PS_STANDBY : k == 3 ? PS_SLEEP : PS_RUN, power_state)
      {manual_reset, standby_req, sleep_req, wdt_reset} <= 4'h0;
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      rd(`OFF_TIMER, k == 3 ? t : `RST_TIMER, "timer");
      rd(`OFF_WDCS, wd_exp(k, w), "wdcs");
      rd(`OFF_RSTCTL, k % 3 ? 32'h1F : r, "rstctl");
      rd(`OFF_PORTAB, k == 4 ? `RST_PORTAB : p, "portab");
      rd(`OFF_PORTC, {24'h0, pc}, "portc");
      $display("test %0d done", k);
    end
    t = $urandom & 32'hFFFF | 32'h1;
    apb(1'b1, `OFF_TIMER, t);
    apb(1'b1, `OFF_CTRL, 32'h2);
    rd(`OFF_STATUS, 32'(PS_STANDBY), "status");
    rd(`OFF_TIMER, `RST_TIMER, "timer");
    apb(1'b1, `OFF_TIMER, t);
    apb(1'b1, `OFF_CTRL, 32'h4);
    rd(`OFF_STATUS, 32'(PS_SLEEP), "status");
    rd(`OFF_TIMER, t, "timer");
    apb(1'b1, `OFF_CTRL, 32'h1);
    rd(`OFF_STATUS, 32'(PS_RUN), "status");
    rd(`OFF_TIMER, `RST_TIMER, "timer");
    $display("test soft control done");
    apb(1'b0, 12'h01C, 32'h0);
    `CHK("slverr", 1'b1, e)
    $display("test unmapped done");
    wrap_up();
  end
  initial begin
    #20000;
    fails++;
    wrap_up();
  end
endmodule : reset_standby_retention_tb_top

// file: test/retention_properties.sv
// Purpose: port checks
// Assumes: pclk only
// Notes: bound below
`timescale 1ns/1ns
`include "retention_map.svh"
module retention_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic manual_reset,
  input wire logic wdt_reset,
  input wire logic [7:0] port_c_pins,
  input wire logic [3:0] init_strobes
);
  // ----------
  // checks
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error alone");
  chk_portc_live: assert property (
    psel && !penable && !pwrite && paddr == `OFF_PORTC |=> prdata[7:0] == $past(port_c_pins))
    else $error("pins");
  chk_timer_clear: assert property (manual_reset |=> init_strobes[3])
    else $error("timer");
  chk_rstctl_src: assert property (
    manual_reset |=> init_strobes[1] == !$past(wdt_reset))
    else $error("rstctl");
  chk_portab_kept: assert property (!init_strobes[0])
    else $error("portab");
endmodule : retention_properties

bind reset_standby_retention retention_properties i_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .manual_reset, .wdt_reset,
  .port_c_pins, .init_strobes);
